// File: logic/acc_pkg.sv
// Purpose: constants and types of the converter control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   all widths fixed; no interrupt logic
package acc_pkg;
    // ****************************************************
    // register map
    // ****************************************************
    localparam logic [11:0] ACC_OFS_CLKEN  = 12'h000;
    localparam logic [11:0] ACC_OFS_MODE   = 12'h004;
    localparam logic [11:0] ACC_OFS_RES    = 12'h008;
    localparam logic [11:0] ACC_OFS_CHAN   = 12'h00C;
    localparam logic [11:0] ACC_OFS_RESULT = 12'h010;
    localparam logic [11:0] ACC_OFS_STATUS = 12'h014;

    // ****************************************************
    // field positions and reset values
    // ****************************************************
    localparam int ACC_BIT_GATE  = 5;
    localparam int ACC_BIT_RUN   = 7;
    localparam int ACC_BIT_FRHI  = 4;
    localparam int ACC_BIT_FRLO  = 3;
    localparam int ACC_BIT_LEN   = 1;
    localparam int ACC_BIT_CMPEN = 0;
    localparam int ACC_BIT_RES   = 0;
    localparam logic [7:0] ACC_RST_CLKEN = 8'h00;
    localparam logic [7:0] ACC_RST_MODE  = 8'h00;
    localparam logic [7:0] ACC_MASK_CLKEN = 8'h20;
    localparam logic [7:0] ACC_MASK_MODE  = 8'h9B;
    localparam logic [7:0] ACC_MASK_RES   = 8'h01;
    localparam logic [7:0] ACC_MASK_CHAN  = 8'h07;

    // ****************************************************
    // conversion timing in conversion clocks
    // ****************************************************
    localparam logic [4:0] ACC_TOTAL_LONG  = 5'h17;
    localparam logic [4:0] ACC_SAMP_LONG   = 5'h09;
    localparam logic [4:0] ACC_TOTAL_SHORT = 5'h11;
    localparam logic [4:0] ACC_SAMP_SHORT  = 5'h03;
    localparam logic [9:0] ACC_MSB_MASK    = 10'h200;
    localparam logic [9:0] ACC_LSB10_MASK  = 10'h001;
    localparam logic [9:0] ACC_LSB8_MASK   = 10'h004;
    localparam logic [2:0] ACC_DIV8_LAST   = 3'h7;
    localparam logic [2:0] ACC_DIV4_LAST   = 3'h3;
    localparam logic [2:0] ACC_DIV2_LAST   = 3'h1;
    localparam logic [2:0] ACC_DIV1_LAST   = 3'h0;

    typedef enum logic [1:0] {
        st_idle,
        st_sample,
        st_trial,
        st_settle
    } acc_state_e;
endpackage : acc_pkg

// File: logic/acc_conversion_control.sv
// Purpose: control logic of a successive-approximation converter
// Assumes: analog comparator outside, answers cmp_above each cycle
// Notes:   registers over APB, zero wait states
// Behaviour
// - clock gate bit cleared stops all converter activity; set supplies it.
// - run bit cleared holds standby; set starts and repeats conversions.
// - comparator enable switches comparator on or off, independent of run.
// - clock select 00 /8, 01 /4, 10 /2, 11 undivided system clock.
// - resolution bit 0 gives a 10-bit result, 1 gives 8-bit.
// - three-bit channel field routes one of eight inputs, binary order.
module acc_conversion_control
    import acc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmp_above,
    output logic      [2:0]  input_channel_select,
    output logic             comparator_on,
    output logic             sample_hold,
    output logic      [9:0]  trial_code,
    output logic             conv_busy,
    output logic             conv_done,
    output logic      [9:0]  conv_result
);

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic [2:0] div_last(input logic [1:0] sel);
        case (sel)
            2'b00:   div_last = ACC_DIV8_LAST;
            2'b01:   div_last = ACC_DIV4_LAST;
            2'b10:   div_last = ACC_DIV2_LAST;
            default: div_last = ACC_DIV1_LAST;
        endcase
    endfunction : div_last

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == ACC_OFS_CLKEN) || (a == ACC_OFS_MODE) ||
                 (a == ACC_OFS_RES) || (a == ACC_OFS_CHAN) ||
                 (a == ACC_OFS_RESULT) || (a == ACC_OFS_STATUS);
    endfunction : mapped

    // ****************************************************
    // declarations
    // ****************************************************
    logic [7:0]  peripheral_clock_enable;
    logic [7:0]  converter_mode_control;
    logic        resolution_select;
    logic        converter_clock_gate;
    logic        conversion_run;
    logic        comparator_enable;
    logic        conv_clock_select_hi;
    logic        conv_clock_select_lo;
    logic        sampling_length_select;
    logic        wr_en;
    logic        rd_setup;
    logic [2:0]  div_cnt;
    logic        conv_tick;
    logic [4:0]  step_cnt;
    logic [4:0]  total_len;
    logic [4:0]  samp_len;
    logic [9:0]  bit_mask;
    logic [9:0]  last_mask;
    logic        keep_bit;
    acc_state_e  state;
    acc_state_e  next_state;

    assign converter_clock_gate   = peripheral_clock_enable[ACC_BIT_GATE];
    assign conversion_run         = converter_mode_control[ACC_BIT_RUN];
    assign conv_clock_select_hi   = converter_mode_control[ACC_BIT_FRHI];
    assign conv_clock_select_lo   = converter_mode_control[ACC_BIT_FRLO];
    assign sampling_length_select = converter_mode_control[ACC_BIT_LEN];
    assign comparator_enable      = converter_mode_control[ACC_BIT_CMPEN];

    // ****************************************************
    // apb slave
    // ****************************************************
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped(paddr);
    assign wr_en    = psel && penable && pwrite && mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_clock_enable <= ACC_RST_CLKEN;
        end else if (wr_en && paddr == ACC_OFS_CLKEN) begin
            peripheral_clock_enable <= pwdata[7:0] & ACC_MASK_CLKEN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_mode_control <= ACC_RST_MODE;
        end else if (wr_en && paddr == ACC_OFS_MODE) begin
            converter_mode_control <= pwdata[7:0] & ACC_MASK_MODE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resolution_select <= 1'b0;
        end else if (wr_en && paddr == ACC_OFS_RES) begin
            resolution_select <= pwdata[ACC_BIT_RES];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_channel_select <= 3'h0;
        end else if (wr_en && paddr == ACC_OFS_CHAN) begin
            input_channel_select <= pwdata[2:0];
        end
    end

    // read data captured in setup so it comes from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                ACC_OFS_CLKEN:  prdata <= {24'h00_0000, peripheral_clock_enable};
                ACC_OFS_MODE:   prdata <= {24'h00_0000, converter_mode_control};
                ACC_OFS_RES:    prdata <= {31'h0000_0000, resolution_select};
                ACC_OFS_CHAN:   prdata <= {29'h0000_0000, input_channel_select};
                ACC_OFS_RESULT: prdata <= {22'h00_0000, conv_result};
                ACC_OFS_STATUS: prdata <= {29'h0000_0000, sample_hold,
                                           comparator_on, conv_busy};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************
    // conversion clock divider
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 3'h0;
        end else if (!converter_clock_gate || conv_tick) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    assign conv_tick = converter_clock_gate &&
        (div_cnt == div_last({conv_clock_select_hi, conv_clock_select_lo}));

    // ****************************************************
    // conversion sequencer
    // ****************************************************
    assign total_len = sampling_length_select ? ACC_TOTAL_SHORT : ACC_TOTAL_LONG;
    assign samp_len  = sampling_length_select ? ACC_SAMP_SHORT : ACC_SAMP_LONG;
    assign last_mask = resolution_select ? ACC_LSB8_MASK : ACC_LSB10_MASK;
    // a disabled comparator never confirms a trial bit
    assign keep_bit  = cmp_above && comparator_enable;

    always_comb begin
        next_state = state;
        case (state)
            st_idle: begin
                if (conversion_run) begin
                    next_state = st_sample;
                end
            end
            st_sample: begin
                if (step_cnt == samp_len - 5'h01) begin
                    next_state = st_trial;
                end
            end
            st_trial: begin
                if (bit_mask == last_mask) begin
                    next_state = st_settle;
                end
            end
            st_settle: begin
                if (step_cnt == total_len - 5'h01) begin
                    next_state = st_sample;
                end
            end
            default: next_state = st_idle;
        endcase
    end

    // run or gate dropping aborts at once, no partial result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
        end else if (!converter_clock_gate || !conversion_run) begin
            state <= st_idle;
        end else if (conv_tick) begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt <= 5'h00;
        end else if (!converter_clock_gate || !conversion_run || state == st_idle) begin
            step_cnt <= 5'h00;
        end else if (conv_tick) begin
            if (state == st_settle && step_cnt == total_len - 5'h01) begin
                step_cnt <= 5'h00;
            end else begin
                step_cnt <= step_cnt + 5'h01;
            end
        end
    end

    // successive approximation register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trial_code <= 10'h000;
            bit_mask   <= 10'h000;
        end else if (conv_tick && state == st_sample && next_state == st_trial) begin
            trial_code <= ACC_MSB_MASK;
            bit_mask   <= ACC_MSB_MASK;
        end else if (conv_tick && state == st_trial && conversion_run
                     && converter_clock_gate) begin
            trial_code <= (keep_bit ? trial_code : (trial_code & ~bit_mask))
                          | (bit_mask == last_mask ? 10'h000 : (bit_mask >> 1));
            bit_mask   <= bit_mask >> 1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_result <= 10'h000;
        end else if (conv_tick && conversion_run && converter_clock_gate
                     && state == st_settle && next_state == st_sample) begin
            if (resolution_select) begin
                conv_result <= {2'b00, trial_code[9:2]};
            end else begin
                conv_result <= trial_code;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_done <= 1'b0;
        end else begin
            conv_done <= conv_tick && conversion_run && converter_clock_gate
                         && state == st_settle && next_state == st_sample;
        end
    end

    // ****************************************************
    // analog side controls
    // ****************************************************
    assign comparator_on = comparator_enable && converter_clock_gate;
    assign sample_hold   = (state == st_sample);
    assign conv_busy     = (state != st_idle);

endmodule : acc_conversion_control

// File: sim/acc_conv_checker.sv
// Purpose: port assertions for the converter control block
// Assumes: zero-wait APB; register bits shadowed from writes
// Notes:   bound to the top module from the bench
module acc_conv_checker
    import acc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  input_channel_select,
    input wire logic        comparator_on,
    input wire logic        sample_hold,
    input wire logic        conv_busy,
    input wire logic        conv_done,
    input wire logic [9:0]  conv_result
);
    timeunit 1ns;
    timeprecision 1ns;
    logic gate;
    logic run;
    logic cmpen;
    logic res;
    logic wr;
    logic unmapped;
    assign wr = psel && penable && pwrite && pready;
    assign unmapped = (paddr[1:0] != 2'h0) || (paddr > ACC_OFS_STATUS);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate  <= 1'b0;
            run   <= 1'b0;
            cmpen <= 1'b0;
            res   <= 1'b0;
        end else if (wr && paddr == ACC_OFS_CLKEN) begin
            gate <= pwdata[ACC_BIT_GATE];
        end else if (wr && paddr == ACC_OFS_MODE) begin
            run   <= pwdata[ACC_BIT_RUN];
            cmpen <= pwdata[ACC_BIT_CMPEN];
        end else if (wr && paddr == ACC_OFS_RES) begin
            res <= pwdata[ACC_BIT_RES];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    done_pulse_a: assert property (conv_done |=> !conv_done)
        else $error("done pulse longer than one cycle");
    sample_busy_a: assert property (sample_hold |-> conv_busy)
        else $error("sampling while idle");
    comp_power_a: assert property (comparator_on == (gate && cmpen))
        else $error("comparator power wrong");
    stop_idle_a: assert property (!(gate && run) |=> !conv_busy)
        else $error("busy while stopped");
    gate_quiet_a: assert property (!gate && !$past(gate) |-> !conv_done)
        else $error("result without clock");
    chan_write_a: assert property (wr && paddr == ACC_OFS_CHAN
        |=> input_channel_select == $past(pwdata[2:0]))
        else $error("channel not routed");
    res8_top_a: assert property (conv_done && res |-> conv_result[9:8] == 2'b00)
        else $error("8-bit result too wide");
    cmp_off_zero_a: assert property (conv_done && !cmpen |-> conv_result == 10'h000)
        else $error("result with comparator off");
    map_error_a: assert property (psel && penable |-> pslverr == unmapped)
        else $error("error response wrong");
    cover property (conv_done && res);
    cover property (conv_done && !res && cmpen);
    cover property (psel && penable && pslverr);
endmodule : acc_conv_checker

// File: sim/acc_keypad_model.sv
// Purpose: resistor-ladder keypad seen through the analog comparator
// Assumes: each channel sits at a fixed ladder tap
// Notes:   comparator off gives a changing, meaningless answer
module acc_keypad_model
    import acc_pkg::*;
(
    input wire logic       pclk,
    input wire logic       comparator_on,
    input wire logic [2:0] input_channel_select,
    input wire logic [9:0] trial_code,
    output logic           cmp_above
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] level;
    logic       noise = 1'b0;
    always_ff @(posedge pclk) noise <= ~noise;
    assign level = {7'h00, input_channel_select} * 10'h08B + 10'h015;
    assign cmp_above = comparator_on ? (level >= trial_code) : noise;
endmodule : acc_keypad_model

// File: sim/acc_conversion_control_tb.sv
// Purpose: self-checking bench for the converter control block
// Assumes: pclk 10 MHz, zero-wait APB answers
// Notes:   undivided clock code is prohibited at 10 MHz, so never selected while the clock gate is set
module acc_conversion_control_tb
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, cmp_above, comparator_on, sample_hold;
    logic        conv_busy, conv_done;
    logic [2:0]  input_channel_select;
    logic [9:0]  trial_code, conv_result;
    int          mismatches = 0;
    int          check_count = 0;
    always #50 pclk = ~pclk;
    acc_conversion_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_above(cmp_above),
        .input_channel_select(input_channel_select), .comparator_on(comparator_on),
        .sample_hold(sample_hold), .trial_code(trial_code), .conv_busy(conv_busy),
        .conv_done(conv_done), .conv_result(conv_result));
    acc_keypad_model pad (.pclk(pclk), .comparator_on(comparator_on),
        .input_channel_select(input_channel_select), .trial_code(trial_code),
        .cmp_above(cmp_above));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, {24'h0, d}, r, e);
    endtask : wr
    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 32'h0, r, e);
        chk(n, x, r);
        chk(n, {31'h0, xe}, {31'h0, e});
    endtask : rd
    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (conv_done !== 1'b1 && n < 2000);
    endtask : wait_done
    task automatic t_regs();
        logic [11:0] adr [4] = '{ACC_OFS_CLKEN, ACC_OFS_MODE, ACC_OFS_RES, ACC_OFS_CHAN};
        logic [7:0]  msk [4] = '{ACC_MASK_CLKEN, ACC_MASK_MODE, ACC_MASK_RES, ACC_MASK_CHAN};
        for (int i = 0; i < 4; i++) begin
            rd("reg_reset", adr[i], 32'h0, 1'b0);
            wr(adr[i], 8'hFF);
            rd("reg_rw", adr[i], {24'h0, msk[i]}, 1'b0);
            wr(adr[i], 8'h00);
        end
        wr(ACC_OFS_RESULT, 8'hFF);
        rd("result_ro", ACC_OFS_RESULT, 32'h0, 1'b0);
        rd("unmapped", 12'h018, 32'h0, 1'b1);
    endtask : t_regs
    task automatic t_gate();
        int n;
        wr(ACC_OFS_MODE, 8'h81);
        repeat (300) @(negedge pclk);
        chk("busy_gated", 32'h0, {31'h0, conv_busy});
        chk("cmp_gated", 32'h0, {31'h0, comparator_on});
        wr(ACC_OFS_CLKEN, 8'h20);
        wait_done(n);
        chk("done_gated", 32'h1, {31'h0, conv_done});
        chk("cmp_on", 32'h1, {31'h0, comparator_on});
        wr(ACC_OFS_MODE, 8'h00);
        // stop lands at the access edge, sequencer idles one edge later
        repeat (2) @(negedge pclk);
        chk("busy_stop", 32'h0, {31'h0, conv_busy});
        rd("status_idle", ACC_OFS_STATUS, 32'h0, 1'b0);
    endtask : t_gate
    task automatic t_timing();
        int n;
        for (int s = 0; s < 3; s++) begin
            for (int l = 0; l < 2; l++) begin
                wr(ACC_OFS_MODE, {3'b100, s[1:0], 1'b0, l[0], 1'b1});
                wait_done(n);
                wait_done(n);
                chk("period", (l ? 17 : 23) * (8 >> s), n);
                wr(ACC_OFS_MODE, 8'h00);
            end
        end
    endtask : t_timing
    task automatic t_chan();
        int         n;
        logic [9:0] lv;
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 8; c++) begin
                lv = {7'h00, c[2:0]} * 10'h08B + 10'h015;
                wr(ACC_OFS_RES, {7'h00, r[0]});
                wr(ACC_OFS_CHAN, {5'h00, c[2:0]});
                wr(ACC_OFS_MODE, 8'h93);
                wait_done(n);
                chk("result", r ? {24'h0, lv[9:2]} : {22'h0, lv}, conv_result);
                wr(ACC_OFS_MODE, 8'h00);
            end
        end
        rd("result_reg", ACC_OFS_RESULT, {24'h0, lv[9:2]}, 1'b0);
        wr(ACC_OFS_MODE, 8'h92);
        wait_done(n);
        chk("result_off", 32'h0, {22'h0, conv_result});
    endtask : t_chan
    initial begin
        #3_000_000;
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_gate();
        t_timing();
        t_chan();
        end_of_test();
    end
endmodule : acc_conversion_control_tb
bind acc_conversion_control acc_conv_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .input_channel_select(input_channel_select),
    .comparator_on(comparator_on), .sample_hold(sample_hold), .conv_busy(conv_busy),
    .conv_done(conv_done), .conv_result(conv_result));
